// *** rtl/io_line_consts.svh ***
// register map and reset values of the io line config block
// assumes a 32-bit apb slave, one aligned word per register
`ifndef IO_LINE_CONSTS_SVH
`define IO_LINE_CONSTS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_OPEN_DRAIN_ENABLE   8'h00
`define OFS_OPEN_DRAIN_DISABLE  8'h04
`define OFS_OPEN_DRAIN_STATE    8'h08
`define OFS_PULLUP_DISABLE      8'h0C
`define OFS_PULLUP_ENABLE       8'h10
`define OFS_PULLUP_STATE        8'h14
`define OFS_FIRST_FUNC_SELECT   8'h18
`define OFS_SECOND_FUNC_SELECT  8'h1C
`define OFS_FUNC_ROUTING_STATE  8'h20
`define OFS_DIRECT_WR_ENABLE    8'h24
`define OFS_DIRECT_WR_DISABLE   8'h28
`define OFS_DIRECT_WR_STATE     8'h2C
`define OFS_OUTPUT_LEVEL        8'h30

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_OPEN_DRAIN    32'h0000_0000
`define RST_PULLUP_OFF    32'h0000_0000
`define RST_ROUTING       32'h0000_0000
`define RST_DIRECT_WR     32'h0000_0000
`define RST_OUTPUT_LEVEL  32'h0000_0000

`endif

// *** rtl/io_line_pkg.sv ***
// types shared by the io line config block
// assumes the constants header is included where offsets are needed
package io_line_pkg;
	typedef logic [31:0] word_t;
	typedef enum logic [1:0]
	{
		ACC_IDLE  = 2'b00,
		ACC_WRITE = 2'b01,
		ACC_READ  = 2'b10
	} acc_t;
endpackage

// *** rtl/set_clear_bank.sv ***
// one bank of per-line bits updated by a set word and a clear word
// assumes set and clear are one-cycle strobes from the same clock
`timescale 1ns/1ps
module set_clear_bank #(
	parameter int          WIDTH = 32,
	parameter logic [31:0] RESET = 32'h0000_0000
) (
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] setBits,
	input  wire logic [WIDTH-1:0] clearBits,
	output logic      [WIDTH-1:0] state
);
	wire logic [WIDTH-1:0] next_state;

	// set and clear never meet on one line: they come from different
	// register writes, or for the level bank from complementary masks of one
	// write, so the order of the terms is only a tie breaker
	assign next_state = (state & ~clearBits) | setBits;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			state <= RESET[WIDTH-1:0];
		else
			state <= next_state;
	end
endmodule

// *** rtl/io_pad_drive.sv ***
// per-line output driver: push-pull or open-drain per line
// assumes the pad resolves level from output value and enable
`timescale 1ns/1ps
module io_pad_drive #(
	parameter int LINES = 32
) (
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	input  wire logic [LINES-1:0] level,
	input  wire logic [LINES-1:0] openDrain,
	output logic      [LINES-1:0] padOut,
	output logic      [LINES-1:0] padOe
);
	wire logic [LINES-1:0] next_padOe;

	assign next_padOe = ~openDrain | ~level;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			padOut <= '0;
			padOe  <= '0;
		end
		else
		begin
			padOut <= level & ~openDrain;
			padOe  <= next_padOe;
		end
	end
endmodule

// *** rtl/io_line_config_registers.sv ***
// per-line configuration of a 32-line parallel io port behind apb
// assumes one clock, async active-low reset, zero-wait apb master
//
// Overview of operation
// - a one written to open_drain_disable turns open-drain off on that line
// - with open-drain off the line is driven both high and low
// - with open-drain on the line is only pulled low, released when high
// - a one written to pullup_disable switches that line's pull-up off
// - a one written to pullup_enable switches that line's pull-up on
// - pullup_state reads zero for pull-up on, one for pull-up off
// - a one written to first_function_select routes line to function one
// - a one written to second_function_select routes line to function two
// - function_routing_state reads zero for function one, one for two
// - a one written to direct_write_enable lets level writes reach line
// - a one written to direct_write_disable blocks level writes to line
// - direct_write_state reads one where level writes reach the line
// - a one written to open_drain_enable turns open-drain on that line
// - output_level_register holds and reads back each line's drive level
`timescale 1ns/1ps
`include "io_line_consts.svh"
module io_line_config_registers #(
	parameter int LINES = 32
) (
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic      [LINES-1:0]  padOut,
	output logic      [LINES-1:0]  padOe,
	output logic      [LINES-1:0]  pullupOn,
	output logic      [LINES-1:0]  secondFunction
);
	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	// setup phase is answered one cycle later; pready is registered so
	// every access takes exactly two cycles (setup + one access cycle)
	wire logic                  setupPhase;
	wire logic                  wrStrobe;
	wire logic                  addrKnown;
	wire logic                  next_pready;
	wire logic                  next_pslverr;
	wire io_line_pkg::word_t    next_prdata;
	wire io_line_pkg::acc_t     access;
	wire logic [LINES-1:0]      wdata;

	function automatic logic wrHit(input logic [7:0] ofs,
		input logic [7:0] addr, input logic we);
		wrHit = we && (addr == ofs);
	endfunction

	assign setupPhase = psel && !penable;
	assign access     = !setupPhase ? io_line_pkg::ACC_IDLE :
		(pwrite ? io_line_pkg::ACC_WRITE : io_line_pkg::ACC_READ);
	// the write lands on the edge where pready is sampled high
	assign wrStrobe   = psel && penable && pready && pwrite;
	assign wdata      = pwdata[LINES-1:0];

	assign addrKnown = (paddr[1:0] == 2'b00) && (paddr <= `OFS_OUTPUT_LEVEL);

	// ---------------------------------------------------------------
	// per-line state banks
	// ---------------------------------------------------------------
	wire logic [LINES-1:0] odSet;
	wire logic [LINES-1:0] odClr;
	wire logic [LINES-1:0] puOffSet;
	wire logic [LINES-1:0] puOffClr;
	wire logic [LINES-1:0] rtSet;
	wire logic [LINES-1:0] rtClr;
	wire logic [LINES-1:0] dwSet;
	wire logic [LINES-1:0] dwClr;
	wire logic [LINES-1:0] lvSet;
	wire logic [LINES-1:0] lvClr;
	wire logic [LINES-1:0] openDrain;
	wire logic [LINES-1:0] pullupOff;
	wire logic [LINES-1:0] routing;
	wire logic [LINES-1:0] directWr;
	wire logic [LINES-1:0] level;
	wire logic             lvWrite;

	assign odSet = wrHit(`OFS_OPEN_DRAIN_ENABLE, paddr, wrStrobe)
		? wdata : '0;
	assign odClr = wrHit(`OFS_OPEN_DRAIN_DISABLE, paddr, wrStrobe)
		? wdata : '0;
	assign puOffSet = wrHit(`OFS_PULLUP_DISABLE, paddr, wrStrobe)
		? wdata : '0;
	assign puOffClr = wrHit(`OFS_PULLUP_ENABLE, paddr, wrStrobe)
		? wdata : '0;
	assign rtSet = wrHit(`OFS_SECOND_FUNC_SELECT, paddr, wrStrobe)
		? wdata : '0;
	assign rtClr = wrHit(`OFS_FIRST_FUNC_SELECT, paddr, wrStrobe)
		? wdata : '0;
	assign dwSet = wrHit(`OFS_DIRECT_WR_ENABLE, paddr, wrStrobe)
		? wdata : '0;
	assign dwClr = wrHit(`OFS_DIRECT_WR_DISABLE, paddr, wrStrobe)
		? wdata : '0;

	// a level write only touches lines whose direct write is enabled
	assign lvWrite = wrHit(`OFS_OUTPUT_LEVEL, paddr, wrStrobe);
	assign lvSet   = lvWrite ? (wdata & directWr) : '0;
	assign lvClr   = lvWrite ? (~wdata & directWr) : '0;

	set_clear_bank #(.WIDTH(LINES), .RESET(`RST_OPEN_DRAIN)) odBank
	(
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.setBits   (odSet),
		.clearBits (odClr),
		.state     (openDrain)
	);

	set_clear_bank #(.WIDTH(LINES), .RESET(`RST_PULLUP_OFF)) puBank
	(
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.setBits   (puOffSet),
		.clearBits (puOffClr),
		.state     (pullupOff)
	);

	set_clear_bank #(.WIDTH(LINES), .RESET(`RST_ROUTING)) rtBank
	(
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.setBits   (rtSet),
		.clearBits (rtClr),
		.state     (routing)
	);

	set_clear_bank #(.WIDTH(LINES), .RESET(`RST_DIRECT_WR)) dwBank
	(
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.setBits   (dwSet),
		.clearBits (dwClr),
		.state     (directWr)
	);

	set_clear_bank #(.WIDTH(LINES), .RESET(`RST_OUTPUT_LEVEL)) lvBank
	(
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.setBits   (lvSet),
		.clearBits (lvClr),
		.state     (level)
	);

	// ---------------------------------------------------------------
	// read mux
	// ---------------------------------------------------------------
	// write-only registers read as zero, no error; only holes error
	io_line_pkg::word_t rdWord;
	always_comb
	begin
		rdWord = 32'h0000_0000;
		case (paddr)
			`OFS_OPEN_DRAIN_STATE:   rdWord[LINES-1:0] = openDrain;
			`OFS_PULLUP_STATE:       rdWord[LINES-1:0] = pullupOff;
			`OFS_FUNC_ROUTING_STATE: rdWord[LINES-1:0] = routing;
			`OFS_DIRECT_WR_STATE:    rdWord[LINES-1:0] = directWr;
			`OFS_OUTPUT_LEVEL:       rdWord[LINES-1:0] = level;
			default:                 rdWord = 32'h0000_0000;
		endcase
	end

	assign next_pready  = (access != io_line_pkg::ACC_IDLE);
	assign next_pslverr = (access != io_line_pkg::ACC_IDLE) && !addrKnown;
	assign next_prdata  = (access == io_line_pkg::ACC_READ && addrKnown)
		? rdWord : 32'h0000_0000;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
		end
	end

	// ---------------------------------------------------------------
	// line outputs
	// ---------------------------------------------------------------
	io_pad_drive #(.LINES(LINES)) pads
	(
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.level     (level),
		.openDrain (openDrain),
		.padOut    (padOut),
		.padOe     (padOe)
	);

	// registered so the pad controls follow the state one cycle later
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pullupOn       <= '1;
			secondFunction <= '0;
		end
		else
		begin
			pullupOn       <= ~pullupOff;
			secondFunction <= routing;
		end
	end
endmodule

// *** tb/io_line_assertions.sv ***
// checker for the io line config block, bound to its top ports
// assumes writes land at the pready edge, outputs follow within two edges
`timescale 1ns/1ps
module io_line_assertions #(
	parameter int LINES = 32
) (
	input wire logic             sys_clk,
	input wire logic             rstn,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic [7:0]       paddr,
	input wire logic [31:0]      pwdata,
	input wire logic [31:0]      prdata,
	input wire logic             pready,
	input wire logic             pslverr,
	input wire logic [LINES-1:0] padOut,
	input wire logic [LINES-1:0] padOe,
	input wire logic [LINES-1:0] pullupOn,
	input wire logic [LINES-1:0] secondFunction
);
	// ----
	// write capture
	// ----
	logic             wrDone;
	logic [LINES-1:0] lastData;
	assign wrDone = psel & penable & pready & pwrite;
	// held apart from pwdata, which the master may change after the access
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn)
			lastData <= '0;
		else if (wrDone)
			lastData <= pwdata[LINES-1:0];
	// ----
	// properties
	// ----
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	chk_ready_after_setup:
	assert property (psel && !penable |-> !pready ##1 pready)
		else $error("pready not one cycle after setup");
	chk_err_unmapped:
	assert property (psel && !penable && paddr > 8'h30
		|=> pready && pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_od_release:
	assert property ((padOut & ~padOe) == '0)
		else $error("line high while released");
	chk_od_on:
	assert property (wrDone && paddr == 8'h00
		|-> ##[1:2] (padOut & lastData) == '0)
		else $error("open drain line driven high");
	chk_pu_on:
	assert property (wrDone && paddr == 8'h10
		|-> ##[1:2] (pullupOn & lastData) == lastData)
		else $error("pull-up not switched on");
	chk_pu_off:
	assert property (wrDone && paddr == 8'h0C
		|-> ##[1:2] (pullupOn & lastData) == '0)
		else $error("pull-up not switched off");
	chk_sel_second:
	assert property (wrDone && paddr == 8'h1C
		|-> ##[1:2] (secondFunction & lastData) == lastData)
		else $error("line not routed to function two");
	chk_sel_first:
	assert property (wrDone && paddr == 8'h18
		|-> ##[1:2] (secondFunction & lastData) == '0)
		else $error("line not routed to function one");
endmodule

// *** tb/io_line_config_registers_test.sv ***
// self-checking bench for the io line config block over apb
// assumes a slave that answers in the access cycle after setup
`timescale 1ns/1ps
module io_line_config_registers_test;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, padOut, padOe, pullupOn, secondFunction, rd;
	logic        pready, pslverr;
	int          n_fail = 0;
	int          comparisons = 0;
	// ----
	// write address, data, read address, expected read
	// ----
	logic [31:0] rows [11][4] = '{
		'{32'h00, 32'hA5A5_0000, 32'h08, 32'hA5A5_0000},
		'{32'h04, 32'h8080_0000, 32'h08, 32'h2525_0000},
		'{32'h0C, 32'h0000_FF00, 32'h14, 32'h0000_FF00},
		'{32'h10, 32'h0000_0F00, 32'h14, 32'h0000_F000},
		'{32'h1C, 32'h1234_5678, 32'h20, 32'h1234_5678},
		'{32'h18, 32'h0000_0078, 32'h20, 32'h1234_5600},
		'{32'h24, 32'h0000_00FF, 32'h2C, 32'h0000_00FF},
		'{32'h28, 32'h0000_000F, 32'h2C, 32'h0000_00F0},
		'{32'h30, 32'hFFFF_FFFF, 32'h30, 32'h0000_00F0},
		'{32'h08, 32'hFFFF_FFFF, 32'h08, 32'h2525_0000},
		'{32'h04, 32'h0000_0000, 32'h04, 32'h0000_0000}};
	io_line_config_registers dut (.sys_clk, .rstn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .padOut,
		.padOe, .pullupOn, .secondFunction);
	initial forever #5 sys_clk = ~sys_clk;
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [31:0] e, s);
		comparisons++;
		if (s !== e)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic finish_test;
		if (n_fail == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		#20000;
		n_fail++;
		finish_test;
	end
	initial
	begin
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk("padOe", 32'hFFFF_FFFF, padOe);
		xfer(1'b0, 8'h14, 32'h0);
		chk("pullup_state", 32'h0, rd);
		foreach (rows[i])
		begin
			xfer(1'b1, rows[i][0][7:0], rows[i][1]);
			xfer(1'b0, rows[i][2][7:0], 32'h0);
			chk("status row", rows[i][3], rd);
		end
		// lines 5:4 go open drain while their level is high
		xfer(1'b1, 8'h00, 32'h30);
		xfer(1'b1, 8'h36, 32'hFFFF_FFFF);
		repeat (3) @(posedge sys_clk);
		chk("padOe", 32'hFFFF_FFCF, padOe);
		chk("padOut", 32'h0000_00C0, padOut);
		chk("pullupOn", 32'hFFFF_0FFF, pullupOn);
		chk("secondFunction", 32'h1234_5600, secondFunction);
		rstn <= 1'b0;
		@(posedge sys_clk);
		chk("pullupOn", 32'hFFFF_FFFF, pullupOn);
		rstn <= 1'b1;
		finish_test;
	end
endmodule
bind io_line_config_registers io_line_assertions #(.LINES(LINES)) chk (
	.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .padOut, .padOe, .pullupOn, .secondFunction);
